// ### pkg/das_pkg.sv
// Constants, register map and types for the defrost and alarm sequencer.
// Assumes a 40 MHz mclk and 16-bit signed temperatures in tenths.
package das_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned SHOW_VAL_S = 2;
   localparam int unsigned SHOW_MSG_S = 1;
   localparam int unsigned SEC_CYC = CLK_HZ;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_AL1 = 8'h04;
   localparam logic [7:0] A_AL2 = 8'h08;
   localparam logic [7:0] A_DEF = 8'h0c;
   localparam logic [7:0] A_DTIME = 8'h10;
   localparam logic [7:0] A_MEAS = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_CMD = 8'h1c;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] AL_RST = 32'h0000_0000;
   localparam logic [31:0] DEF_RST = 32'h0000_0000;
   localparam logic [31:0] DTIME_RST = 32'h000a_0064;
   // Field positions in CTRL
   localparam int CT_COOL = 0;
   localparam int CT_PID = 1;
   localparam int CT_SND = 2;
   localparam int CT_LATCH = 3;
   localparam int CT_MAN = 4;
   localparam int CT_TUNE = 5;
   localparam int CT_SENSF = 6;
   localparam int CT_BIN_LO = 8;
   localparam int CT_AUXF_LO = 12;
   localparam int CT_MANV_LO = 16;
   localparam logic [3:0] AUXF_DEFROST = 4'h9;
   localparam logic [2:0] BIN_ALRST = 3'h2;
   localparam logic [2:0] BIN_DEFROST = 3'h5;
   localparam logic [9:0] PCT_FULL = 10'h3e8;
   localparam logic [1:0] CMD_CLR = 2'h3;
   typedef enum logic [1:0] {
      DM_OFF = 2'h0, DM_CYCLIC = 2'h1, DM_ONDEMAND = 2'h2
   } das_dmode_t;
   typedef enum logic [1:0] {
      DS_IDLE = 2'b00, DS_PEND = 2'b01, DS_RUN = 2'b11
   } das_dstate_t;
endpackage

// ### hw/das_top.sv
// Alarm evaluation, manual override and defrost sequencing, AXI4-Lite regs.
// Assumes measured value, set point and keys are synchronous to mclk.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module das_top
   import das_pkg::*;
#(
   parameter int unsigned TICK_CYC = SEC_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] measured_value,
   input wire logic [15:0] set_point,
   input wire logic bin_contact,
   input wire logic cooling_output,
   input wire logic key_clear_pair,
   input wire logic key_display,
   input wire logic [9:0] auto_signal,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [1:0] alarm_out,
   output logic sound_alarm,
   output logic [9:0] control_signal,
   output logic manual_led,
   output logic show_percent,
   output logic show_defrost_msg,
   output logic auxiliary_output,
   output logic defrost_active
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] al1;
      logic [31:0] al2;
      logic [31:0] def;
      logic [31:0] dtime;
      logic aw_got;
      logic w_got;
      logic [4:0] aw_a;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] alarm;
      logic [1:0] latched;
      logic bin_prev;
      das_dstate_t dst;
      logic [31:0] tick;
      logic [15:0] sec_run;
      logic [15:0] sec_int;
      logic [1:0] ph;
      logic [9:0] csig;
      logic blink;
      logic sound;
      logic aux;
      logic pct;
   } das_state_t;

   das_state_t st_ff, nxt_st;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Hysteresis comparator: returns the new alarm level
   function automatic logic hyst(input logic prev,
                                 input logic signed [16:0] q,
                                 input logic signed [16:0] thr,
                                 input logic signed [16:0] hy,
                                 input logic low);
      logic hi_on;
      logic hi_off;
      hi_on = low ? (q < thr - hy) : (q > thr + hy);
      hi_off = low ? (q > thr + hy) : (q < thr - hy);
      hyst = hi_on || (prev && !hi_off);
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      wmerge = r;
   endfunction

   logic signed [16:0] pv_s;
   logic signed [16:0] dev_s;
   logic [2:0] bin_fn;
   das_dmode_t dmode;
   logic end_by_temp;
   logic [15:0] dend;
   logic start_ok;
   logic reached_end;
   logic bin_edge;
   logic clr_req;
   logic wr_fire;
   logic abort;
   logic [9:0] man_v;

   assign pv_s = {measured_value[15], measured_value};
   assign dev_s = {set_point[15], set_point} - pv_s;
   assign bin_fn = st_ff.ctrl[CT_BIN_LO +: 3];
   assign dmode = das_dmode_t'(st_ff.def[1:0]);
   assign end_by_temp = st_ff.def[2];
   assign dend = st_ff.def[31:16];
   assign bin_edge = bin_contact && !st_ff.bin_prev;
   assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;

   // Start interlocks
   assign start_ok = ($signed(measured_value) <= $signed(set_point)) &&
      !cooling_output &&
      ($signed(measured_value) < $signed(dend));
   assign reached_end = end_by_temp && !st_ff.ctrl[CT_SENSF] &&
      ($signed(measured_value) >= $signed(dend));
   assign abort = st_ff.ctrl[CT_MAN] || st_ff.ctrl[CT_TUNE] ||
      (dmode == DM_OFF && st_ff.dst == DS_RUN &&
       !st_ff.def[3]);

   // Manual value snapped to 0/100 % under on-off control
   always_comb begin
      man_v = st_ff.ctrl[CT_MANV_LO +: 10];
      if (man_v > PCT_FULL) begin
         man_v = PCT_FULL;
      end
      if (!st_ff.ctrl[CT_PID]) begin
         man_v = (man_v >= PCT_FULL / 10'd2) ? PCT_FULL : 10'h000;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic req_new;
      logic sec_tick;
      logic run_done;
      logic [31:0] wv;
      req_new = 1'b0;
      sec_tick = 1'b0;
      run_done = 1'b0;
      wv = 32'h0000_0000;
      nxt_st = st_ff;
      clr_req = 1'b0;

      // Bus write channel: address and data in either order
      if (s_axi_awvalid && !st_ff.aw_got) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_a = {s_axi_awaddr, 1'b0};
      end
      if (s_axi_wvalid && !st_ff.w_got) begin
         nxt_st.w_got = 1'b1;
         nxt_st.w_d = s_axi_wdata;
         nxt_st.w_s = s_axi_wstrb;
      end
      if (wr_fire) begin
         nxt_st.bvalid = 1'b1;
         wv = st_ff.w_d;
         unique case ({3'h0, st_ff.aw_a})
            A_CTRL: nxt_st.ctrl = wmerge(st_ff.ctrl, wv, st_ff.w_s);
            A_AL1: nxt_st.al1 = wmerge(st_ff.al1, wv, st_ff.w_s);
            A_AL2: nxt_st.al2 = wmerge(st_ff.al2, wv, st_ff.w_s);
            A_DEF: nxt_st.def = wmerge(st_ff.def, wv, st_ff.w_s);
            A_DTIME: nxt_st.dtime = wmerge(st_ff.dtime, wv, st_ff.w_s);
            A_CMD: clr_req = st_ff.w_s[0] && wv[1:0] == CMD_CLR;
            default: ;
         endcase
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
      end

      // Bus read channel
      if (s_axi_arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = 2'h0;
         unique case ({3'h0, s_axi_araddr[4:2], 2'h0})
            A_CTRL: nxt_st.rdata = st_ff.ctrl;
            A_AL1: nxt_st.rdata = st_ff.al1;
            A_AL2: nxt_st.rdata = st_ff.al2;
            A_DEF: nxt_st.rdata = st_ff.def;
            A_DTIME: nxt_st.rdata = st_ff.dtime;
            A_MEAS: nxt_st.rdata = {16'h0000, measured_value};
            A_STAT: nxt_st.rdata = {16'h0000, 6'h00, st_ff.csig};
            default: nxt_st.rdata = {24'h000000, st_ff.latched,
               st_ff.alarm, st_ff.aux, st_ff.sound, st_ff.dst};
         endcase
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end

      // Alarms: al fields [15:0] threshold, [27:16] hysteresis,
      // [28] relative, [29] low side, [30] enable
      // Key pair clears only in normal mode; in manual mode it has no effect
      clr_req = clr_req || (key_clear_pair && !st_ff.ctrl[CT_MAN]) ||
         (bin_fn == BIN_ALRST && bin_edge);
      for (int a = 0; a < 2; a++) begin
         logic [31:0] c;
         logic lvl;
         c = (a == 0) ? st_ff.al1 : st_ff.al2;
         lvl = hyst(st_ff.alarm[a], c[28] ? dev_s : pv_s,
            {c[15], c[15:0]}, {5'h00, c[27:16]}, c[29]);
         nxt_st.alarm[a] = c[30] && lvl;
         if (st_ff.ctrl[CT_LATCH] && nxt_st.alarm[a]) begin
            nxt_st.latched[a] = 1'b1;
         end else if (clr_req || !st_ff.ctrl[CT_LATCH]) begin
            nxt_st.latched[a] = 1'b0;
         end
      end
      nxt_st.sound = st_ff.ctrl[CT_SND] &&
         (|nxt_st.alarm || |nxt_st.latched);

      // Seconds timebase
      nxt_st.tick = st_ff.tick + 32'd1;
      if (st_ff.tick >= TICK_CYC - 1) begin
         nxt_st.tick = 32'h0000_0000;
         sec_tick = 1'b1;
      end

      // Manual mode and percentage display
      nxt_st.csig = st_ff.ctrl[CT_MAN] ? man_v : auto_signal;
      nxt_st.pct = key_display || st_ff.ctrl[CT_MAN];
      if (sec_tick) begin
         nxt_st.blink = st_ff.ctrl[CT_MAN] && !st_ff.blink;
      end
      if (!st_ff.ctrl[CT_MAN]) begin
         nxt_st.blink = 1'b0;
      end

      // Defrost sequencer
      nxt_st.bin_prev = bin_contact;
      if (bin_fn == BIN_DEFROST && bin_edge) begin
         req_new = 1'b1;
      end
      if (dmode == DM_CYCLIC && st_ff.dst != DS_RUN && sec_tick) begin
         if (st_ff.sec_int + 16'd1 >= st_ff.dtime[15:0]) begin
            req_new = 1'b1;
            nxt_st.sec_int = 16'h0000;
         end else begin
            nxt_st.sec_int = st_ff.sec_int + 16'd1;
         end
      end
      if (dmode == DM_ONDEMAND) begin
         req_new = 1'b1;
      end
      if (!st_ff.ctrl[CT_COOL]) begin
         req_new = 1'b0;
      end
      unique case (st_ff.dst)
         DS_IDLE: begin
            if (req_new) begin
               nxt_st.dst = DS_PEND;
            end
         end
         DS_PEND: begin
            // Manual mode and self-tuning hold the request, not drop it
            if (!st_ff.ctrl[CT_COOL]) begin
               nxt_st.dst = DS_IDLE;
            end else if (start_ok && !st_ff.ctrl[CT_MAN] &&
               !st_ff.ctrl[CT_TUNE]) begin
               nxt_st.dst = DS_RUN;
               nxt_st.sec_run = 16'h0000;
               nxt_st.ph = 2'h0;
               nxt_st.def[3] = bin_fn == BIN_DEFROST && dmode == DM_OFF;
            end
         end
         DS_RUN: begin
            if (sec_tick) begin
               nxt_st.sec_run = st_ff.sec_run + 16'd1;
               nxt_st.ph = (st_ff.ph == 2'h2) ? 2'h0 : st_ff.ph + 2'h1;
            end
            run_done = reached_end ||
               (sec_tick && st_ff.sec_run + 16'd1 >=
                st_ff.dtime[31:16]);
            if (abort || !st_ff.ctrl[CT_COOL]) begin
               nxt_st.dst = DS_IDLE;
            end else if (run_done) begin
               nxt_st.dst = DS_IDLE;
               nxt_st.sec_int = 16'h0000;
               if (dmode == DM_ONDEMAND) begin
                  nxt_st.def[1:0] = DM_OFF;
               end
            end
         end
         default: nxt_st.dst = DS_IDLE;
      endcase
      nxt_st.aux = nxt_st.dst == DS_RUN &&
         st_ff.ctrl[CT_AUXF_LO +: 4] == AUXF_DEFROST;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
         st_ff.ctrl <= CTRL_RST;
         st_ff.al1 <= AL_RST;
         st_ff.al2 <= AL_RST;
         st_ff.def <= DEF_RST;
         st_ff.dtime <= DTIME_RST;
         st_ff.dst <= DS_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = !st_ff.aw_got;
   assign s_axi_wready = !st_ff.w_got;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = 2'h0;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign alarm_out = st_ff.alarm | st_ff.latched;
   assign sound_alarm = st_ff.sound;
   assign control_signal = st_ff.csig;
   assign manual_led = st_ff.blink;
   assign show_percent = st_ff.pct;
   assign defrost_active = st_ff.dst == DS_RUN;
   // Two seconds of value, then one of message
   assign show_defrost_msg = defrost_active && st_ff.ph == 2'h2;
   assign auxiliary_output = st_ff.aux;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_cool_only;
      @(posedge mclk) disable iff (!nrst)
      !st_ff.ctrl[CT_COOL] |=> !defrost_active;
   endproperty
   a_cool_only: assert property (p_cool_only) else $error("no cool");
   // Nothing may start while an interlock is unmet
   property p_start;
      @(posedge mclk) disable iff (!nrst)
      !defrost_active && !start_ok |=> !defrost_active;
   endproperty
   a_start: assert property (p_start) else $error("start interlock");
   property p_abort;
      @(posedge mclk) disable iff (!nrst)
      defrost_active && st_ff.ctrl[CT_MAN] |=> !defrost_active;
   endproperty
   a_abort: assert property (p_abort) else $error("manual abort");
   property p_sound;
      @(posedge mclk) disable iff (!nrst)
      !st_ff.ctrl[CT_SND] |=> !sound_alarm;
   endproperty
   a_sound: assert property (p_sound) else $error("sound disabled");
   property p_aux;
      @(posedge mclk) disable iff (!nrst)
      auxiliary_output == (defrost_active &&
         $past(st_ff.ctrl[CT_AUXF_LO +: 4]) == AUXF_DEFROST);
   endproperty
   a_aux: assert property (p_aux) else $error("aux outside defrost");
   // Message only ever follows the two value phases of a running defrost
   property p_msg;
      @(posedge mclk) disable iff (!nrst)
      $rose(show_defrost_msg) |-> $past(defrost_active) &&
         $past(st_ff.ph) == 2'h1;
   endproperty
   a_msg: assert property (p_msg) else $error("message phase");
   property p_manual;
      @(posedge mclk) disable iff (!nrst)
      st_ff.ctrl[CT_MAN] && !st_ff.ctrl[CT_PID] && $stable(st_ff.ctrl)
      |=> control_signal == 10'h000 || control_signal == PCT_FULL;
   endproperty
   a_manual: assert property (p_manual) else $error("on-off manual");
   property p_latch;
      @(posedge mclk) disable iff (!nrst)
      st_ff.ctrl[CT_LATCH] && st_ff.latched[0] && !clr_req
      ##1 st_ff.ctrl[CT_LATCH] |-> st_ff.latched[0];
   endproperty
   a_latch: assert property (p_latch) else $error("latch lost");

   c_run: cover property (@(posedge mclk) disable iff (!nrst)
      st_ff.dst == DS_PEND ##1 defrost_active);
   c_alarm: cover property (@(posedge mclk) disable iff (!nrst) sound_alarm);
   c_aux: cover property (@(posedge mclk) disable iff (!nrst)
      auxiliary_output);
endmodule

// ### bench/das_plant_model.sv
// Plant model: coil temperature, compressor output and binary contact.
// Assumes the bench loads temperatures and sets the contact level.
`timescale 1ns/10ps
module das_plant_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic defrost_active,
   input wire logic warm,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic [15:0] set_point,
   input wire logic close_req,
   output logic [15:0] measured_value,
   output logic cooling_output,
   output logic bin_contact
);
   logic slow_ff;
   // Heaters warm the coil a tenth every other cycle, so ends are slow
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         measured_value <= 16'h0000;
         slow_ff <= 1'b0;
      end else begin
         slow_ff <= !slow_ff;
         if (load)
            measured_value <= load_val;
         else if (warm && defrost_active && slow_ff)
            measured_value <= measured_value + 16'h0001;
      end
   end
   // Compressor runs above set point plus a margin, never in defrost
   assign cooling_output = !defrost_active &&
      ($signed(measured_value) > $signed(set_point) + 20);
   assign bin_contact = close_req;
endmodule

// ### bench/das_top_tb_top.sv
// Self-checking bench: register bus, alarms, manual mode and defrost.
// Assumes the plant model drives sensor, compressor and contact pins.
`timescale 1ns/10ps
module das_top_tb_top
   import das_pkg::*;
;
   localparam int unsigned TK = 10;
   localparam logic [31:0] CB = 32'h0000_9001;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] set_point = 16'h0064;
   logic key_clear_pair = 1'b0;
   logic key_display = 1'b0;
   logic [9:0] auto_signal = 10'h000;
   logic [3:0] awaddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [4:0] araddr = 5'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic warm = 1'b0, load = 1'b0, close_req = 1'b0;
   logic [15:0] load_val = 16'h0000;
   logic [15:0] measured_value;
   logic bin_contact, cooling_output, awready, wready, bvalid;
   logic arready, rvalid, sound_alarm, manual_led, show_percent;
   logic show_defrost_msg, auxiliary_output, defrost_active;
   logic [1:0] bresp, rresp, alarm_out;
   logic [31:0] rdata;
   logic [9:0] control_signal;
   logic [7:0] obs;
   logic [31:0] exp_q[$];
   int mismatches = 0;
   int tests_run = 0;

   always #12.5 mclk = ~mclk;
   assign obs = {show_percent, manual_led, auxiliary_output,
      show_defrost_msg, sound_alarm, alarm_out, defrost_active};

   das_top #(.TICK_CYC(TK)) u_das_top (.mclk(mclk), .nrst(nrst),
      .measured_value(measured_value), .set_point(set_point),
      .bin_contact(bin_contact), .cooling_output(cooling_output),
      .key_clear_pair(key_clear_pair), .key_display(key_display),
      .auto_signal(auto_signal), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .alarm_out(alarm_out),
      .sound_alarm(sound_alarm), .control_signal(control_signal),
      .manual_led(manual_led), .show_percent(show_percent),
      .show_defrost_msg(show_defrost_msg),
      .auxiliary_output(auxiliary_output),
      .defrost_active(defrost_active));

   das_plant_model u_das_plant_model (.mclk(mclk), .nrst(nrst),
      .defrost_active(defrost_active), .warm(warm), .load(load),
      .load_val(load_val), .set_point(set_point), .close_req(close_req),
      .measured_value(measured_value), .cooling_output(cooling_output),
      .bin_contact(bin_contact));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Bounded wait for one observed output to reach a level
   task automatic wait_on(input int s, input logic v, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge mclk);
         if (obs[s] === v) break;
      end
      chk($sformatf("obs%0d", s), {31'h0, v}, {31'h0, obs[s]});
      if (obs[s] !== v) tally_and_finish;
   endtask

   task automatic hold_chk(input int s, input logic v, input int n);
      repeat (n) @(negedge mclk);
      chk($sformatf("obs%0d", s), {31'h0, v}, {31'h0, obs[s]});
   endtask

   task automatic pv(input logic [15:0] v);
      @(posedge mclk);
      load <= 1'b1;
      load_val <= v;
      @(posedge mclk);
      load <= 1'b0;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      awaddr <= a[4:1];
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk("bresp", 32'h0, {30'h0, bresp});
      chk("bwait", 32'h0, {31'h0, i == 50});
      if (i == 50) tally_and_finish;
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
      int i;
      exp_q.push_back(e);
      @(posedge mclk);
      araddr <= a[4:0];
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk("rwait", 32'h0, {31'h0, i == 50});
      if (i == 50) tally_and_finish;
   endtask

   // Oldest expected read word meets each read answer
   always @(posedge mclk) begin
      if (rvalid && rready && exp_q.size() > 0)
         chk("rdata", exp_q.pop_front(), rdata);
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      int k;
      void'($urandom(11));
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      axi_rd(A_CTRL, CTRL_RST);
      axi_rd(A_AL1, AL_RST);
      axi_rd(A_DEF, DEF_RST);
      axi_rd(A_DTIME, DTIME_RST);
      axi_wr(A_CTRL, 32'h0000_0004);
      axi_wr(A_AL1, 32'h400a_00c8);
      pv(16'h012c + 16'($urandom_range(99)));
      wait_on(1, 1'b1, 8);
      wait_on(3, 1'b1, 8);
      hold_chk(2, 1'b0, 4);
      pv(16'h00c8);
      hold_chk(1, 1'b1, 20);
      pv(16'($urandom_range(150)));
      wait_on(1, 1'b0, 8);
      pv(16'h00c8);
      hold_chk(1, 1'b0, 20);
      axi_wr(A_CTRL, CTRL_RST);
      pv(16'h012c);
      hold_chk(3, 1'b0, 20);
      set_point <= 16'h012c;
      axi_wr(A_AL2, 32'h5005_0032);
      pv(16'h00c8);
      wait_on(2, 1'b1, 8);
      pv(16'h0122);
      wait_on(2, 1'b0, 8);
      axi_wr(A_AL2, AL_RST);
      set_point <= 16'h0064;
      // Latched alarm cleared by command, key pair and contact in turn
      for (k = 0; k < 3; k++) begin
         axi_wr(A_CTRL, 32'h0000_0208);
         pv(16'h012c);
         wait_on(1, 1'b1, 8);
         pv(16'h0000);
         hold_chk(1, 1'b1, 20);
         @(posedge mclk);
         if (k == 0) axi_wr(A_CMD, {30'h0, CMD_CLR});
         else if (k == 1) key_clear_pair <= 1'b1;
         else close_req <= 1'b1;
         wait_on(1, 1'b0, 8);
         @(posedge mclk);
         key_clear_pair <= 1'b0;
         close_req <= 1'b0;
      end
      axi_wr(A_AL1, AL_RST);
      auto_signal <= 10'($urandom_range(1000));
      key_display <= 1'b1;
      wait_on(7, 1'b1, 8);
      hold_chk(7, 1'b1, 3);
      chk("ctl", {22'h0, auto_signal}, {22'h0, control_signal});
      axi_wr(A_CTRL, 32'h03e8_0010);
      hold_chk(7, 1'b1, 4);
      chk("ctl", {22'h0, PCT_FULL}, {22'h0, control_signal});
      wait_on(6, 1'b1, 25);
      wait_on(6, 1'b0, 25);
      axi_wr(A_CTRL, 32'h0219_0012);
      hold_chk(7, 1'b1, 4);
      chk("ctl", 32'h0000_0219, {22'h0, control_signal});
      axi_wr(A_CTRL, CTRL_RST);
      key_display <= 1'b0;
      // Defrost: no cooling type, pending start, then end on temperature
      axi_wr(A_DTIME, 32'h003c_0005);
      warm <= 1'b1;
      axi_wr(A_DEF, 32'h0032_0006);
      hold_chk(0, 1'b0, 30);
      axi_wr(A_DEF, DEF_RST);
      axi_wr(A_CTRL, CB);
      pv(16'h0096);
      axi_wr(A_DEF, 32'h0032_0006);
      hold_chk(0, 1'b0, 30);
      pv(16'h0000);
      wait_on(0, 1'b1, 10);
      wait_on(5, 1'b1, 4);
      hold_chk(4, 1'b0, 8);
      wait_on(4, 1'b1, 25);
      wait_on(4, 1'b0, 14);
      wait_on(0, 1'b0, 120);
      wait_on(5, 1'b0, 4);
      axi_rd(A_DEF, 32'h0032_0004);
      axi_wr(A_DTIME, 32'h0003_0005);
      // Time-only end, then time end with temperature end set but a faulty sensor
      for (k = 0; k < 2; k++) begin
         axi_wr(A_CTRL, CB | {25'h0, k[0], 6'h0});
         pv(16'h0000);
         axi_wr(A_DEF, {16'h0005, 13'h0, k[0], 2'h2});
         wait_on(0, 1'b1, 10);
         hold_chk(0, 1'b1, 15);
         wait_on(0, 1'b0, 20);
      end
      // Contact edges: plain run, then aborts by manual and self-tuning
      axi_wr(A_CTRL, CB | 32'h0500);
      axi_wr(A_DEF, 32'h0005_0000);
      for (k = 0; k < 3; k++) begin
         pv(16'h0000);
         close_req <= 1'b1;
         wait_on(0, 1'b1, 10);
         if (k == 0) begin
            wait_on(0, 1'b0, 40);
            pv(16'h0000);
            hold_chk(0, 1'b0, 40);
         end else begin
            axi_wr(A_CTRL, CB | 32'h0500 | (32'h8 << k));
            wait_on(0, 1'b0, 4);
            axi_wr(A_CTRL, CB | 32'h0500);
         end
         @(posedge mclk);
         close_req <= 1'b0;
      end
      pv(16'h0000);
      axi_wr(A_DEF, 32'h0005_0001);
      wait_on(0, 1'b1, 60);
      wait_on(0, 1'b0, 40);
      pv(16'h0000);
      hold_chk(0, 1'b0, 30);
      wait_on(0, 1'b1, 30);
      axi_wr(A_DEF, DEF_RST);
      wait_on(0, 1'b0, 4);
      tally_and_finish;
   end
endmodule
